/* File: design/nvsc_defs.vh */
// constants for the host-side nvsram bus controller
`ifndef NVSC_DEFS_VH
`define NVSC_DEFS_VH

// ****************************************
// software sequence addresses (low 14 bits)
// ****************************************
`define NVSC_SEQ_A1 14'h0E38
`define NVSC_SEQ_A2 14'h31C7
`define NVSC_SEQ_A3 14'h03E0
`define NVSC_SEQ_A4 14'h3C1F
`define NVSC_SEQ_A5 14'h303F
`define NVSC_SEQ_SAVE 14'h0FC0
`define NVSC_SEQ_RESTORE 14'h0C63

// ****************************************
// command codes
// ****************************************
`define NVSC_CMD_READ 2'h0
`define NVSC_CMD_WRITE 2'h1
`define NVSC_CMD_SAVE 2'h2
`define NVSC_CMD_RESTORE 2'h3

// ****************************************
// timing counts in clock cycles; save and restore counts derived from times in us and the clock in MHz
// ****************************************
`define NVSC_SETUP_CYC 16'h0001
`define NVSC_STROBE_CYC 16'h0002
`define NVSC_SAVE_TIME_US 10000
`define NVSC_RESTORE_TIME_US 20000
`define NVSC_CLK_MHZ 10
`define NVSC_SAVE_CYC (`NVSC_SAVE_TIME_US * `NVSC_CLK_MHZ)
`define NVSC_RESTORE_CYC (`NVSC_RESTORE_TIME_US * `NVSC_CLK_MHZ)

`endif

/* File: design/nvsc_host.v */
// host controller that drives the nvsram parallel bus
`timescale 1ns/1ps
`include "nvsc_defs.vh"

// Operation
// - host holds address stable through write
// - host keeps oe high during writes
// - host keeps write off during restore
// - first five sequence reads fixed addresses
// - sixth read 0x0FC0 starts save
// - sequence uses reads only, oe optional
// - sixth read 0x0C63 starts restore
module nvsc_host #(
  parameter SAVE_CYC = `NVSC_SAVE_CYC,
  parameter RESTORE_CYC = `NVSC_RESTORE_CYC
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_cmd_valid,
  input wire [1:0] i_cmd,
  input wire [14:0] i_cmd_addr,
  input wire [7:0] i_cmd_wdata,
  output wire o_cmd_ready,
  output reg o_rsp_valid,
  output reg [7:0] o_rsp_rdata,
  output reg o_busy,
  input wire i_power_ok,
  output reg [14:0] o_addr_in,
  output reg o_chip_enable_n,
  output reg o_output_enable_n,
  output reg o_write_enable_n,
  input wire [7:0] i_data_io,
  output reg [7:0] o_data_io,
  output reg o_data_io_oe_n
);

  // ****************************************
  // states
  // ****************************************
  localparam ST_IDLE = 3'h0;  // waiting for a command
  localparam ST_SETUP = 3'h1; // address settling, strobes high
  localparam ST_STROBE = 3'h2; // ce low for the access
  localparam ST_END = 3'h3;   // strobes back high
  localparam ST_WAIT = 3'h4;  // device busy with nonvolatile cycle
  localparam ST_PWR = 3'h5;   // waiting out power-up restore

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [7:0] data_meta; // first stage, read only by data_sync
  reg [7:0] data_sync;
  reg pwr_meta;        // first stage, read only by pwr_sync
  reg pwr_sync;

  // two flops on every pin input
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      data_meta <= 8'h00;
      data_sync <= 8'h00;
      pwr_meta <= 1'b0;
      pwr_sync <= 1'b0;
    end else begin
      data_meta <= i_data_io;
      data_sync <= data_meta;
      pwr_meta <= i_power_ok;
      pwr_sync <= pwr_meta;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] cmd;        // command in progress
  reg [2:0] step;       // sequence step, 0..5
  reg [31:0] count;     // cycle counter per phase
  reg [31:0] next_count;

  // sequence address for a given step; sixth depends on command
  function [13:0] seq_addr;
    input [2:0] s;
    input [1:0] c;
    begin
      case (s)
        3'h0: seq_addr = `NVSC_SEQ_A1;
        3'h1: seq_addr = `NVSC_SEQ_A2;
        3'h2: seq_addr = `NVSC_SEQ_A3;
        3'h3: seq_addr = `NVSC_SEQ_A4;
        3'h4: seq_addr = `NVSC_SEQ_A5;
        default: seq_addr = (c == `NVSC_CMD_RESTORE) ? `NVSC_SEQ_RESTORE : `NVSC_SEQ_SAVE;
      endcase
    end
  endfunction

  // a new command only in idle with power good
  assign o_cmd_ready = (state == ST_IDLE) && pwr_sync;

  wire is_seq = (cmd == `NVSC_CMD_SAVE) || (cmd == `NVSC_CMD_RESTORE);
  wire last_step = (step == 3'h5);

  // ****************************************
  // next state logic
  // ****************************************
  always @* begin
    next_state = state;
    next_count = count + 32'h0000_0001;
    case (state)
      ST_IDLE: begin
        next_count = 32'h0000_0000;
        if (!pwr_sync) begin
          next_state = ST_PWR;
        end else if (i_cmd_valid) begin
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (count + 32'h0000_0001 >= {16'h0000, `NVSC_SETUP_CYC}) begin
          next_state = ST_STROBE;
          next_count = 32'h0000_0000;
        end
      end
      ST_STROBE: begin
        if (count + 32'h0000_0001 >= {16'h0000, `NVSC_STROBE_CYC}) begin
          next_state = ST_END;
          next_count = 32'h0000_0000;
        end
      end
      ST_END: begin
        next_count = 32'h0000_0000;
        if (is_seq && !last_step) begin
          next_state = ST_SETUP; // next step back to back, nothing between
        end else if (is_seq) begin
          next_state = ST_WAIT;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_WAIT: begin
        // bus left alone until the nonvolatile cycle ends
        if (count + 32'h0000_0001 >= SAVE_CYC) begin
          next_state = ST_IDLE;
          next_count = 32'h0000_0000;
        end
      end
      ST_PWR: begin
        // restore runs after power returns; keep write off meanwhile
        if (!pwr_sync) begin
          next_count = 32'h0000_0000;
        end else if (count + 32'h0000_0001 >= RESTORE_CYC) begin
          next_state = ST_IDLE;
          next_count = 32'h0000_0000;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_count = 32'h0000_0000;
      end
    endcase
  end

  // ****************************************
  // state, counter and command capture
  // ****************************************
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_PWR; // device restores at power-up, wait it out
      count <= 32'h0000_0000;
      cmd <= `NVSC_CMD_READ;
      step <= 3'h0;
    end else begin
      state <= next_state;
      count <= next_count;
      if (state == ST_IDLE && next_state == ST_SETUP) begin
        cmd <= i_cmd;
        step <= 3'h0;
      end else if (state == ST_END && is_seq && !last_step) begin
        step <= step + 3'h1;
      end
    end
  end

  // ****************************************
  // bus pins and response
  // ****************************************
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_addr_in <= 15'h0000;
      o_chip_enable_n <= 1'b1;
      o_output_enable_n <= 1'b1;
      o_write_enable_n <= 1'b1;
      o_data_io <= 8'h00;
      o_data_io_oe_n <= 1'b1;
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= 8'h00;
      o_busy <= 1'b1;
    end else begin
      o_rsp_valid <= 1'b0;
      o_busy <= (next_state == ST_WAIT) || (next_state == ST_PWR);
      case (next_state)
        ST_SETUP: begin
          // address set while all strobes high
          if (state == ST_IDLE) begin
            o_addr_in <= i_cmd_addr;
            o_data_io <= i_cmd_wdata;
          end
          if (next_state == ST_SETUP && (state == ST_END || state == ST_IDLE) &&
              ((state == ST_IDLE && (i_cmd == `NVSC_CMD_SAVE || i_cmd == `NVSC_CMD_RESTORE)) ||
               (state == ST_END))) begin
            // msb left low; only 14 bits matter to the detector
            o_addr_in <= {1'b0, seq_addr((state == ST_IDLE) ? 3'h0 : step + 3'h1,
              (state == ST_IDLE) ? i_cmd : cmd)};
          end
          o_chip_enable_n <= 1'b1;
          o_output_enable_n <= 1'b1;
          o_write_enable_n <= 1'b1;
        end
        ST_STROBE: begin
          // address unchanged through the strobe
          o_chip_enable_n <= 1'b0;
          if (cmd == `NVSC_CMD_WRITE) begin
            o_write_enable_n <= 1'b0;
            o_output_enable_n <= 1'b1;
            o_data_io_oe_n <= 1'b0;
          end else begin
            // sequence steps are reads too; oe used so data is seen
            o_write_enable_n <= 1'b1;
            o_output_enable_n <= 1'b0;
          end
        end
        default: begin
          // strobes and data released on one edge; device took data a cycle before
          o_chip_enable_n <= 1'b1;
          o_output_enable_n <= 1'b1;
          o_write_enable_n <= 1'b1;
          o_data_io_oe_n <= 1'b1;
          if (state == ST_END && cmd == `NVSC_CMD_READ) begin
            // two sync flops put the byte sampled in the first strobe cycle here one cycle after ce rises
            o_rsp_rdata <= data_sync;
          end
          if (state == ST_END && !is_seq) begin
            o_rsp_valid <= 1'b1;
          end
          if (state == ST_WAIT && next_state == ST_IDLE) begin
            o_rsp_valid <= 1'b1; // nonvolatile cycle done
          end
        end
      endcase
    end
  end

endmodule

/* File: verif/nvsc_monitor.sv */
// port assertions for the host bus controller
`timescale 1ns/1ps
`include "nvsc_defs.vh"
module nvsc_monitor (
  input wire i_clock,
  input wire i_rst,
  input wire i_cmd_valid,
  input wire [1:0] i_cmd,
  input wire o_cmd_ready,
  input wire o_rsp_valid,
  input wire o_busy,
  input wire i_power_ok,
  input wire [14:0] o_addr_in,
  input wire o_chip_enable_n,
  input wire o_output_enable_n,
  input wire o_write_enable_n,
  input wire o_data_io_oe_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // accepted command this edge
  wire take = i_cmd_valid && o_cmd_ready;
  sequence rd_on;
    !o_chip_enable_n && !o_output_enable_n && o_write_enable_n;
  endsequence
  sequence wr_on;
    !o_chip_enable_n && !o_write_enable_n && !o_data_io_oe_n;
  endsequence
  chk_read_frame: assert property (take && i_cmd == `NVSC_CMD_READ |->
    ##2 rd_on [*2] ##1 o_chip_enable_n ##1 o_rsp_valid) else $error("bad read frame");
  chk_write_frame: assert property (take && i_cmd == `NVSC_CMD_WRITE |->
    ##2 wr_on [*2] ##1 o_write_enable_n ##1 o_rsp_valid) else $error("bad write frame");
  chk_seq_start: assert property (take && i_cmd == `NVSC_CMD_SAVE |->
    ##2 rd_on ##0 (o_addr_in == {1'b0, `NVSC_SEQ_A1})) else $error("bad first step");
  chk_oe_write: assert property (!o_write_enable_n |-> o_output_enable_n)
    else $error("oe low in write");
  chk_no_fight: assert property (!o_data_io_oe_n |-> o_output_enable_n)
    else $error("bus contention");
  chk_addr_hold: assert property (!o_write_enable_n |-> $stable(o_addr_in))
    else $error("address moved in write");
  chk_busy_gate: assert property (o_busy |-> !o_cmd_ready)
    else $error("ready while busy");
  chk_power_gate: assert property (!i_power_ok [*3] |-> !o_cmd_ready)
    else $error("ready on low power");
endmodule

/* File: verif/nvsc_nvram_model.sv */
// behavioural nonvolatile sram facing the controller
`timescale 1ns/1ps
`include "nvsc_defs.vh"
module nvsc_nvram_model #(parameter BUSY_CYC = 15) (
  input wire i_clock,
  input wire i_power_ok,
  input wire [14:0] i_addr_in,
  input wire i_chip_enable_n,
  input wire i_output_enable_n,
  input wire i_write_enable_n,
  input wire [7:0] i_data_io,
  output wire [7:0] o_data_io,
  output integer o_save_cnt = 0,
  output integer o_restore_cnt = 0
);
  reg [7:0] mem [0:32767];
  reg [7:0] shadow [0:32767];
  reg [7:0] last = 0, d_lat = 0;
  reg [14:0] a_lat = 0;
  reg dirty = 0, rd_act = 0, wr_act = 0, pow = 0;
  integer busy = 0, step = 0, k;
  logic [13:0] sq [5] = '{`NVSC_SEQ_A1, `NVSC_SEQ_A2, `NVSC_SEQ_A3, `NVSC_SEQ_A4, `NVSC_SEQ_A5};
  // idle bus shows the inverse of the last byte, never a stale copy
  // read drive only with write high and no nonvolatile cycle running
  wire drive = !i_chip_enable_n && !i_output_enable_n &&
    i_write_enable_n && busy == 0;
  assign o_data_io = drive ? mem[i_addr_in] : ~last;
  task save;
    for (k = 0; k < 32768; k++) shadow[k] = mem[k];
    o_save_cnt++; dirty = 0; busy = BUSY_CYC;
  endtask
  task restore;
    for (k = 0; k < 32768; k++) mem[k] = shadow[k];
    o_restore_cnt++; dirty = 0; busy = BUSY_CYC;
  endtask
  // cycles are framed by strobe edges, seen on the model clock
  always @(posedge i_clock) begin
    if (drive) last <= mem[i_addr_in];
    pow <= i_power_ok;
    if (i_power_ok && !pow) restore;
    else if (busy > 0) busy = busy - 1;
    else if (!i_power_ok && pow && dirty) save;
    else begin
      if (wr_act && !(!i_chip_enable_n && !i_write_enable_n)) begin
        if (i_power_ok) begin mem[a_lat] = d_lat; dirty = 1; end
        step = 0;
      end
      if (rd_act && i_chip_enable_n) begin
        if (step == 5 && a_lat[13:0] == `NVSC_SEQ_SAVE) save;
        else if (step == 5 && a_lat[13:0] == `NVSC_SEQ_RESTORE) restore;
        // a miss restarts the count, counting itself if it is the first address
        step = (step < 5 && a_lat[13:0] == sq[step]) ? step + 1 :
          a_lat[13:0] == sq[0];
      end
      rd_act = !i_chip_enable_n && i_write_enable_n;
      wr_act = !i_chip_enable_n && !i_write_enable_n;
      a_lat = i_addr_in;
      d_lat = i_data_io;
    end
  end
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the host bus controller
`timescale 1ns/1ps
`include "nvsc_defs.vh"
module testbench;
  reg i_clock = 0, i_rst = 1, cv = 0, pw = 0;
  reg [1:0] cmd = 0;
  reg [14:0] ca = 0;
  reg [7:0] wd = 0, got;
  wire rdy, rv, busy, ce_n, oe_n, we_n, hoe_n;
  wire [14:0] addr;
  wire [7:0] rdata, hout, dout, bus;
  wire [31:0] scnt, rcnt;
  // no save before the first command; one restore at power-up
  integer err_count = 0, cmp_count = 0, cyc = 0, n, sc = 0, rc = 1;
  logic [7:0] rm [int], rs [int];
  logic [13:0] sq [5] = '{`NVSC_SEQ_A1, `NVSC_SEQ_A2, `NVSC_SEQ_A3, `NVSC_SEQ_A4, `NVSC_SEQ_A5};
  assign bus = hoe_n ? dout : hout;
  nvsc_host #(.SAVE_CYC(20), .RESTORE_CYC(20)) dut (.i_clock(i_clock), .i_rst(i_rst),
    .i_cmd_valid(cv), .i_cmd(cmd), .i_cmd_addr(ca), .i_cmd_wdata(wd), .o_cmd_ready(rdy),
    .o_rsp_valid(rv), .o_rsp_rdata(rdata), .o_busy(busy), .i_power_ok(pw), .o_addr_in(addr),
    .o_chip_enable_n(ce_n), .o_output_enable_n(oe_n), .o_write_enable_n(we_n),
    .i_data_io(bus), .o_data_io(hout), .o_data_io_oe_n(hoe_n));
  nvsc_nvram_model mdl (.i_clock(i_clock), .i_power_ok(pw), .i_addr_in(addr),
    .i_chip_enable_n(ce_n), .i_output_enable_n(oe_n), .i_write_enable_n(we_n),
    .i_data_io(bus), .o_data_io(dout), .o_save_cnt(scnt), .o_restore_cnt(rcnt));
  initial forever #50 i_clock = ~i_clock;
  // hang guard, far above the whole sequence
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin err_count++; complete_run; end
  end
  task complete_run;
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task check(input [7:0] g, input [7:0] e);
    cmp_count++;
    if (g !== e) begin err_count++; $display("[FAIL] %0t got %h want %h", $time, g, e); end
  endtask
  // expected byte at an address, from the reference copy
  function automatic logic [7:0] exp_byte(input int a);
    return rm[a];
  endfunction
  // one command; expectations follow it in the reference copies
  task op(input [1:0] c, input [14:0] a, input [7:0] d);
    while (rdy !== 1'b1) begin @(posedge i_clock); #1; end
    cmd = c; ca = a; wd = d; cv = 1;
    @(posedge i_clock); #1 cv = 0;
    while (rv !== 1'b1) begin @(posedge i_clock); #1; end
    got = rdata;
    if (c == `NVSC_CMD_WRITE) rm[a] = d;
    if (c == `NVSC_CMD_SAVE) begin rs = rm; sc++; end
    if (c == `NVSC_CMD_RESTORE) begin rm = rs; rc++; end
  endtask
  task counts;
    check(scnt[7:0], sc[7:0]);
    check(rcnt[7:0], rc[7:0]);
  endtask
  // hand-made sequence; brk slips a stray read in after that step
  task seq(input msb, input integer brk);
    for (n = 0; n < 5; n++) begin
      op(`NVSC_CMD_READ, {msb, sq[n]}, 0);
      if (n == brk) op(`NVSC_CMD_READ, 15'h0123, 0);
    end
    op(`NVSC_CMD_READ, {msb, `NVSC_SEQ_SAVE}, 0);
    repeat (20) @(posedge i_clock);
    #1;
  endtask
  task power(input v);
    pw = v;
    repeat (40) @(posedge i_clock);
    #1;
  endtask
  initial begin
    n = $urandom(32'h5101);
    repeat (20) @(posedge i_clock);
    #1 i_rst = 0;
    pw = 1;
    op(`NVSC_CMD_WRITE, 15'h0000, 8'h5a);
    op(`NVSC_CMD_WRITE, 15'h7fff, 8'ha5);
    repeat (12) op(`NVSC_CMD_WRITE, 15'($urandom), 8'($urandom));
    foreach (rm[a]) begin
      op(`NVSC_CMD_READ, 15'(a), 0);
      check(got, exp_byte(a));
    end
    op(`NVSC_CMD_SAVE, 0, 0);
    op(`NVSC_CMD_SAVE, 0, 0);
    counts;
    op(`NVSC_CMD_WRITE, 15'h0000, 8'h11);
    op(`NVSC_CMD_RESTORE, 0, 0);
    op(`NVSC_CMD_READ, 15'h0000, 0);
    check(got, 8'h5a);
    seq(0, 2);
    counts;
    seq(1, 9);
    sc++;
    counts;
    power(0);
    power(1);
    rc++;
    counts;
    op(`NVSC_CMD_WRITE, 15'h2222, 8'hc3);
    power(0);
    power(1);
    sc++;
    rc++;
    counts;
    op(`NVSC_CMD_READ, 15'h2222, 0);
    check(got, 8'hc3);
    complete_run;
  end
endmodule
bind nvsc_host nvsc_monitor mon (.i_clock(i_clock), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
  .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid), .o_busy(o_busy),
  .i_power_ok(i_power_ok), .o_addr_in(o_addr_in), .o_chip_enable_n(o_chip_enable_n),
  .o_output_enable_n(o_output_enable_n), .o_write_enable_n(o_write_enable_n),
  .o_data_io_oe_n(o_data_io_oe_n));
